// ==== common/pim_pkg.sv ====
package pim_pkg;
  // ------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [15:0] R_IO_IRQ_EN_0_7 = 16'h2006;
  localparam logic [15:0] R_IO_FLAGS_0_7 = 16'h2007;
  localparam logic [15:0] R_MODE_CTRL = 16'h2015;
  localparam logic [15:0] R_SYS_STATUS = 16'h2016;
  localparam logic [15:0] R_PERIPH_FLAGS = 16'h2017;
  localparam logic [15:0] R_IO_IRQ_EN_8 = 16'h2046;
  localparam logic [15:0] R_IO_FLAG_8 = 16'h2047;
  localparam logic [15:0] R_PIN_FUNC_SEL = 16'h2049;
  localparam logic [15:0] R_SW_SHUTDOWN = 16'h2061;
  localparam logic [15:0] R_INT_MASK = 16'h3100;
  localparam logic [15:0] R_INT_FORCE_CLEAR = 16'h3101;
  localparam logic [15:0] R_INT_SENSE_CTRL = 16'h3102;
  localparam logic [15:0] R_PERIPH_IRQ_EN = 16'h3103;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int MODE_RX_PIN_SEL_BIT = 4;
  localparam int MODE_UART_BIT = 5;
  localparam int MASK_PERIPH_BIT = 9;
  localparam int SENSE_RX_BIT = 0;
  localparam int SENSE_TX_BIT = 1;
  localparam int SENSE_PERIPH_BIT = 2;
  localparam int SENSE_NEST_BIT = 4;
  localparam int FLAG_TRIP_BIT = 0;
  localparam int FLAG_SYNC_BIT = 1;
  localparam logic [7:0] PIN_FUNC_SEL_RST = 8'hFF;
  localparam logic [1:0] PERIPH_IRQ_EN_RST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] VT_LAST = 6'h2F;
  // ------------------------------------------------------------
  // core interrupt sources, index 0 is the highest priority
  // ------------------------------------------------------------
  localparam int NSRC = 9;
  localparam logic [3:0] I_TRIP = 4'h0;
  localparam logic [3:0] I_PERIPH = 4'h1;
  localparam logic [3:0] I_SYNC = 4'h2;
  localparam logic [3:0] I_IO = 4'h3;
  localparam logic [3:0] I_SW1 = 4'h4;
  localparam logic [3:0] I_SW0 = 4'h5;
  localparam logic [3:0] I_TX = 4'h6;
  localparam logic [3:0] I_RX = 4'h7;
  localparam logic [3:0] I_TIMER = 4'h8;
  localparam logic [15:0] VEC [NSRC] = '{16'h002C, 16'h0004, 16'h000C, 16'h0008,
    16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028};

  typedef enum logic [0:0] {ST_BOOT = 1'b0, ST_RUN = 1'b1} pim_boot_type;

  typedef struct packed {
    logic trip_n;
    logic current_sense_input_oc;
    logic [8:0] io;
    logic rx_a;
    logic rx_b;
    logic rx_fsync;
  } pim_pins_type;

  typedef struct packed {
    pim_pins_type s1;
    pim_pins_type s2;
  } pim_sync_state_type;

  typedef struct packed {
    pim_boot_type boot;
    logic [5:0] bcnt;
    logic aw_ok;
    logic [15:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic sync_d;
    logic trip_d;
    logic isen_d;
    logic [8:0] io_d;
    logic [1:0] pflags;
    logic [1:0] perien;
    logic [8:0] ioflag;
    logic [8:0] ioen;
    logic [7:0] pinsel;
    logic [1:0] mode;
    logic [9:0] interrupt_mask_reg;
    logic [4:0] interrupt_sense_control_reg;
    logic [8:0] latch;
    logic [8:0] insvc;
    logic rx_d;
    logic tx_d;
    logic shared_peripheral_irq_line_n;
    logic shared_peripheral_irq_line_d;
    logic int_req;
    logic [3:0] cur_idx;
    logic [15:0] int_vec;
    logic dr;
    logic rx_fs;
    logic fl_o;
    logic fs_oe_n;
  } pim_state_type;

  localparam pim_state_type STATE_RST = '{boot: ST_BOOT, pinsel: PIN_FUNC_SEL_RST,
    perien: PERIPH_IRQ_EN_RST, shared_peripheral_irq_line_n: 1'b1, shared_peripheral_irq_line_d: 1'b1, rx_d: 1'b1, tx_d: 1'b1,
    fs_oe_n: 1'b1, default: '0};
endpackage

// ==== rtl/pim_sync2.sv ====
`timescale 1ns/1ps
module pim_sync2
(
  input wire logic clk,
  input wire logic nrst,
  input pim_pkg::pim_pins_type pins_in,
  output pim_pkg::pim_pins_type pins_out
);
  pim_pkg::pim_sync_state_type s;
  pim_pkg::pim_sync_state_type next_s;

  // first stage feeds only the second stage
  always_comb
  begin
    next_s.s1 = pins_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign pins_out = s.s2;
endmodule

// ==== rtl/pim_prio.sv ====
`timescale 1ns/1ps
module pim_prio
(
  input wire logic [8:0] req,
  output logic found,
  output logic [3:0] idx
);
  // lowest set index wins
  always_comb
  begin
    found = 1'b0;
    idx = 4'h0;
    for (int i = 8; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

// ==== rtl/pim_top.sv ====
// Notes on behaviour
// - all peripheral sources merge onto shared line
// - sync interrupt on rising sync pulse
// - trip on pin fall, overcurrent, shutdown write
// - io interrupt on any enabled line change
// - fixed vector table, trip highest, timer lowest
// - peripheral interrupts need mask bit nine
// - low byte clears, high byte forces
// - software interrupts only through force bits
// - sense bits select edge or level
// - sense bit four enables nesting
// - vector table copied to program RAM
// - direct vector branch, no extra latency
// - flags hold shared line until read
// - reading peripheral flags clears and acknowledges
// - reading an io flag register clears only the flags it returns
// - highest priority pending served first
// - mode bit four picks receive pin
// - mode bit five selects uart wiring
// - select bit set means general io
`timescale 1ns/1ps
module pim_top
#(
  parameter logic [23:0] DEFAULT_VECTOR_WORD = 24'h0A001F
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [17:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [17:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input pim_pkg::pim_pins_type PINS,
  input wire logic PWM_PERIOD_SYNC_PULSE,
  input wire logic TIMER_IRQ,
  input wire logic SERIAL_RECEIVE_IRQ_N,
  input wire logic SERIAL_TRANSMIT_IRQ_N,
  input wire logic CORE_FLAG_OUTPUT,
  input wire logic INT_ACK,
  input wire logic INT_RETURN,
  output logic SHARED_PERIPHERAL_IRQ_LINE_N,
  output logic INT_REQ,
  output logic [15:0] INT_VECTOR,
  output logic PRAM_WE,
  output logic [5:0] PRAM_ADDR,
  output logic [23:0] PRAM_DATA,
  output logic SERIAL_RECEIVE_INTERNAL_INPUT,
  output logic RECEIVE_FRAME_SYNC_INTERNAL,
  output logic RECEIVE_FRAME_SYNC_PIN_O,
  output logic RECEIVE_FRAME_SYNC_PIN_OE_N,
  output logic [7:0] PIN_IS_GPIO
);
  pim_pkg::pim_state_type s;
  pim_pkg::pim_state_type next_s;
  pim_pkg::pim_pins_type ps;
  logic [8:0] pend;
  logic [8:0] req;
  logic pg;
  logic cand_found;
  logic [3:0] cand_idx;
  logic svc_found;
  logic [3:0] svc_idx;
  logic wr_go;
  logic rd_go;
  logic [31:0] bm;
  logic sw_trip_wr;
  logic [7:0] ifc_clr;
  logic [7:0] ifc_frc;
  logic sync_evt;
  logic trip_evt;
  logic [8:0] io_evt;
  logic dr_mux;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pim_sync2 u_sync
  (
    .clk(CLK),
    .nrst(NRST),
    .pins_in(PINS),
    .pins_out(ps)
  );

  // ------------------------------------------------------------
  // pending and request vectors
  // ------------------------------------------------------------
  always_comb
  begin
    pend = s.latch;
    pend[pim_pkg::I_RX] = s.latch[pim_pkg::I_RX]
      | (~s.interrupt_sense_control_reg[pim_pkg::SENSE_RX_BIT] & ~SERIAL_RECEIVE_IRQ_N);
    pend[pim_pkg::I_TX] = s.latch[pim_pkg::I_TX]
      | (~s.interrupt_sense_control_reg[pim_pkg::SENSE_TX_BIT] & ~SERIAL_TRANSMIT_IRQ_N);
    pend[pim_pkg::I_PERIPH] = s.latch[pim_pkg::I_PERIPH]
      | (~s.interrupt_sense_control_reg[pim_pkg::SENSE_PERIPH_BIT] & ~s.shared_peripheral_irq_line_n);
    // peripheral vectors only open through the shared line
    pg = pend[pim_pkg::I_PERIPH] & s.interrupt_mask_reg[pim_pkg::MASK_PERIPH_BIT];
    req = '0;
    req[pim_pkg::I_TRIP] = pg & s.pflags[pim_pkg::FLAG_TRIP_BIT];
    req[pim_pkg::I_SYNC] = pg & s.pflags[pim_pkg::FLAG_SYNC_BIT];
    req[pim_pkg::I_IO] = pg & (|s.ioflag);
    req[pim_pkg::I_PERIPH] = pg & ~(|s.pflags) & ~(|s.ioflag);
    req[pim_pkg::I_SW1] = pend[pim_pkg::I_SW1] & s.interrupt_mask_reg[4];
    req[pim_pkg::I_SW0] = pend[pim_pkg::I_SW0] & s.interrupt_mask_reg[3];
    req[pim_pkg::I_TX] = pend[pim_pkg::I_TX] & s.interrupt_mask_reg[2];
    req[pim_pkg::I_RX] = pend[pim_pkg::I_RX] & s.interrupt_mask_reg[1];
    req[pim_pkg::I_TIMER] = pend[pim_pkg::I_TIMER] & s.interrupt_mask_reg[0];
  end

  pim_prio u_cand
  (
    .req(req),
    .found(cand_found),
    .idx(cand_idx)
  );

  pim_prio u_svc
  (
    .req(s.insvc),
    .found(svc_found),
    .idx(svc_idx)
  );

  assign wr_go = s.aw_ok & s.w_ok & ~s.bvalid;
  assign rd_go = S_AXI_ARVALID & ~s.rvalid;
  assign bm = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
  assign dr_mux = s.mode[0] ? ps.rx_b : ps.rx_a;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    sw_trip_wr = 1'b0;
    ifc_clr = '0;
    ifc_frc = '0;
    // bus: address and data may arrive in either order
    if (S_AXI_AWVALID & ~s.aw_ok)
    begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = S_AXI_AWADDR[17:2];
    end
    if (S_AXI_WVALID & ~s.w_ok)
    begin
      next_s.w_ok = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end
    if (s.bvalid & S_AXI_BREADY)
      next_s.bvalid = 1'b0;
    if (s.rvalid & S_AXI_RREADY)
      next_s.rvalid = 1'b0;
    if (wr_go)
    begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = pim_pkg::RESP_OKAY;
      case (s.awaddr)
        pim_pkg::R_IO_IRQ_EN_0_7:
          next_s.ioen[7:0] = (s.ioen[7:0] & ~bm[7:0]) | (s.wdata[7:0] & bm[7:0]);
        pim_pkg::R_IO_IRQ_EN_8:
          next_s.ioen[8] = bm[0] ? s.wdata[0] : s.ioen[8];
        pim_pkg::R_MODE_CTRL:
          next_s.mode = bm[0] ? s.wdata[5:4] : s.mode;
        pim_pkg::R_PIN_FUNC_SEL:
          next_s.pinsel = (s.pinsel & ~bm[7:0]) | (s.wdata[7:0] & bm[7:0]);
        pim_pkg::R_SW_SHUTDOWN:
          sw_trip_wr = 1'b1;
        pim_pkg::R_INT_MASK:
          next_s.interrupt_mask_reg = (s.interrupt_mask_reg & ~bm[9:0]) | (s.wdata[9:0] & bm[9:0]);
        pim_pkg::R_INT_FORCE_CLEAR:
        begin
          ifc_clr = s.wdata[7:0] & bm[7:0];
          ifc_frc = s.wdata[15:8] & bm[15:8];
        end
        pim_pkg::R_INT_SENSE_CTRL:
          next_s.interrupt_sense_control_reg = (s.interrupt_sense_control_reg & ~bm[4:0]) | (s.wdata[4:0] & bm[4:0]);
        pim_pkg::R_PERIPH_IRQ_EN:
          next_s.perien = (s.perien & ~bm[1:0]) | (s.wdata[1:0] & bm[1:0]);
        pim_pkg::R_IO_FLAGS_0_7, pim_pkg::R_IO_FLAG_8, pim_pkg::R_SYS_STATUS,
        pim_pkg::R_PERIPH_FLAGS:
          next_s.bresp = pim_pkg::RESP_OKAY;
        default:
          next_s.bresp = pim_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = pim_pkg::RESP_OKAY;
      next_s.rdata = '0;
      case (S_AXI_ARADDR[17:2])
        pim_pkg::R_IO_IRQ_EN_0_7: next_s.rdata[7:0] = s.ioen[7:0];
        pim_pkg::R_IO_IRQ_EN_8: next_s.rdata[0] = s.ioen[8];
        pim_pkg::R_MODE_CTRL: next_s.rdata[5:4] = s.mode;
        pim_pkg::R_PIN_FUNC_SEL: next_s.rdata[7:0] = s.pinsel;
        pim_pkg::R_SW_SHUTDOWN: next_s.rdata = '0;
        pim_pkg::R_INT_MASK: next_s.rdata[9:0] = s.interrupt_mask_reg;
        pim_pkg::R_INT_FORCE_CLEAR: next_s.rdata = '0;
        pim_pkg::R_INT_SENSE_CTRL: next_s.rdata[4:0] = s.interrupt_sense_control_reg;
        pim_pkg::R_PERIPH_IRQ_EN: next_s.rdata[1:0] = s.perien;
        pim_pkg::R_SYS_STATUS: next_s.rdata[0] = ps.trip_n;
        pim_pkg::R_PERIPH_FLAGS:
        begin
          next_s.rdata[1:0] = s.pflags;
          next_s.pflags = '0;
        end
        pim_pkg::R_IO_FLAGS_0_7:
        begin
          next_s.rdata[7:0] = s.ioflag[7:0];
          next_s.ioflag[7:0] = '0;
        end
        pim_pkg::R_IO_FLAG_8:
        begin
          next_s.rdata[0] = s.ioflag[8];
          next_s.ioflag[8] = 1'b0;
        end
        default: next_s.rresp = pim_pkg::RESP_SLVERR;
      endcase
    end
    // peripheral events; sets come after the read clears so they win
    sync_evt = PWM_PERIOD_SYNC_PULSE & ~s.sync_d;
    trip_evt = (s.trip_d & ~ps.trip_n) | (ps.current_sense_input_oc & ~s.isen_d) | sw_trip_wr;
    io_evt = (ps.io ^ s.io_d) & s.ioen;
    next_s.sync_d = PWM_PERIOD_SYNC_PULSE;
    next_s.trip_d = ps.trip_n;
    next_s.isen_d = ps.current_sense_input_oc;
    next_s.io_d = ps.io;
    if (sync_evt & s.perien[pim_pkg::FLAG_SYNC_BIT])
      next_s.pflags[pim_pkg::FLAG_SYNC_BIT] = 1'b1;
    if (trip_evt & s.perien[pim_pkg::FLAG_TRIP_BIT])
      next_s.pflags[pim_pkg::FLAG_TRIP_BIT] = 1'b1;
    next_s.ioflag = next_s.ioflag | io_evt;
    // shared line stays low while any enabled flag is unread
    next_s.shared_peripheral_irq_line_n = ~((|(next_s.pflags & next_s.perien))
      | (|(next_s.ioflag & next_s.ioen)));
    next_s.shared_peripheral_irq_line_d = s.shared_peripheral_irq_line_n;
    next_s.rx_d = SERIAL_RECEIVE_IRQ_N;
    next_s.tx_d = SERIAL_TRANSMIT_IRQ_N;
    // core latches: clear first, then ack, then sets
    for (int k = 0; k < 8; k++)
    begin
      if (ifc_clr[k])
        next_s.latch[8 - k] = 1'b0;
    end
    if (INT_ACK & s.int_req)
    begin
      next_s.latch[s.cur_idx] = 1'b0;
      next_s.insvc[s.cur_idx] = 1'b1;
    end
    if (INT_RETURN & svc_found)
      next_s.insvc[svc_idx] = 1'b0;
    if (TIMER_IRQ)
      next_s.latch[pim_pkg::I_TIMER] = 1'b1;
    if (s.rx_d & ~SERIAL_RECEIVE_IRQ_N & s.interrupt_sense_control_reg[pim_pkg::SENSE_RX_BIT])
      next_s.latch[pim_pkg::I_RX] = 1'b1;
    if (s.tx_d & ~SERIAL_TRANSMIT_IRQ_N & s.interrupt_sense_control_reg[pim_pkg::SENSE_TX_BIT])
      next_s.latch[pim_pkg::I_TX] = 1'b1;
    if (s.shared_peripheral_irq_line_d & ~s.shared_peripheral_irq_line_n & s.interrupt_sense_control_reg[pim_pkg::SENSE_PERIPH_BIT])
      next_s.latch[pim_pkg::I_PERIPH] = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      if (ifc_frc[k])
        next_s.latch[8 - k] = 1'b1;
    end
    // dispatch straight to the vector of the best candidate
    next_s.int_req = (s.boot == pim_pkg::ST_RUN) & cand_found & ~INT_ACK
      & (~svc_found | (s.interrupt_sense_control_reg[pim_pkg::SENSE_NEST_BIT] & (cand_idx < svc_idx)));
    next_s.cur_idx = cand_idx;
    next_s.int_vec = pim_pkg::VEC[cand_idx];
    // boot copy of the default vector table
    if (s.boot == pim_pkg::ST_BOOT)
    begin
      next_s.bcnt = s.bcnt + 6'h01;
      if (s.bcnt == pim_pkg::VT_LAST)
        next_s.boot = pim_pkg::ST_RUN;
    end
    // serial receive steering
    next_s.dr = dr_mux;
    next_s.rx_fs = s.mode[1] ? dr_mux : ps.rx_fsync;
    next_s.fl_o = CORE_FLAG_OUTPUT;
    next_s.fs_oe_n = ~s.mode[1];
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      s <= pim_pkg::STATE_RST;
    else
      s <= next_s;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign S_AXI_AWREADY = ~s.aw_ok;
  assign S_AXI_WREADY = ~s.w_ok;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = ~s.rvalid;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RRESP = s.rresp;
  assign S_AXI_RDATA = s.rdata;
  assign SHARED_PERIPHERAL_IRQ_LINE_N = s.shared_peripheral_irq_line_n;
  assign INT_REQ = s.int_req;
  assign INT_VECTOR = s.int_vec;
  assign PRAM_WE = (s.boot == pim_pkg::ST_BOOT);
  assign PRAM_ADDR = s.bcnt;
  assign PRAM_DATA = DEFAULT_VECTOR_WORD;
  assign SERIAL_RECEIVE_INTERNAL_INPUT = s.dr;
  assign RECEIVE_FRAME_SYNC_INTERNAL = s.rx_fs;
  assign RECEIVE_FRAME_SYNC_PIN_O = s.fl_o;
  assign RECEIVE_FRAME_SYNC_PIN_OE_N = s.fs_oe_n;
  assign PIN_IS_GPIO = s.pinsel;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  AST_SYNC_FLAG: assert property (
    (sync_evt && s.perien[1]) |=> (s.pflags[1] && !SHARED_PERIPHERAL_IRQ_LINE_N))
    else $error("sync edge did not raise flag and shared line");
  AST_SW_TRIP: assert property (
    (wr_go && s.awaddr == pim_pkg::R_SW_SHUTDOWN && s.perien[0]) |=> s.pflags[0])
    else $error("shutdown write did not set trip flag");
  AST_IO_FLAG: assert property (
    (io_evt != 9'h000) |=> ((s.ioflag & $past(io_evt)) == $past(io_evt)))
    else $error("io change not flagged");
  AST_LINE_HOLD: assert property (
    (!SHARED_PERIPHERAL_IRQ_LINE_N && !rd_go && !wr_go) |=> !SHARED_PERIPHERAL_IRQ_LINE_N)
    else $error("shared line released without a flag read");
  AST_TRIP_VEC: assert property (
    (INT_REQ && s.cur_idx == 4'h0) |-> (INT_VECTOR == 16'h002C))
    else $error("trip vector wrong");
  AST_PERIPH_MASK: assert property (
    (INT_REQ && s.cur_idx <= 4'h3) |-> $past(s.interrupt_mask_reg[9]))
    else $error("peripheral interrupt passed while masked");
  AST_PRIO: assert property (
    $rose(INT_REQ) |-> (($past(req) & ((9'h001 << s.cur_idx) - 9'h001)) == 9'h000))
    else $error("lower priority served first");
  AST_FLAG_RD: assert property (
    (rd_go && S_AXI_ARADDR[17:2] == pim_pkg::R_PERIPH_FLAGS && !sync_evt && !trip_evt)
    |=> (s.pflags == 2'h0))
    else $error("flag read did not clear");
  AST_IO_RD: assert property (
    (rd_go && S_AXI_ARADDR[17:2] == pim_pkg::R_IO_FLAGS_0_7 && io_evt[7:0] == 8'h00)
    |=> (s.ioflag[7:0] == 8'h00))
    else $error("io flag read did not clear");
  AST_SW_ONLY: assert property (
    $rose(s.latch[5]) |-> $past(wr_go && s.awaddr == pim_pkg::R_INT_FORCE_CLEAR && s.wdata[11]))
    else $error("software interrupt raised without force write");
  AST_IFC_CLR: assert property (
    (wr_go && s.awaddr == pim_pkg::R_INT_FORCE_CLEAR && ifc_clr[3] && !ifc_frc[3])
    |=> !s.latch[5])
    else $error("clear bit did not clear software interrupt zero");
  AST_NEST: assert property (
    (INT_REQ && !s.interrupt_sense_control_reg[4]) |-> (s.insvc == 9'h000))
    else $error("nested dispatch while nesting off");
  AST_RX_SEL: assert property (
    ##1 (SERIAL_RECEIVE_INTERNAL_INPUT
      == ($past(s.mode[0]) ? $past(ps.rx_b) : $past(ps.rx_a))))
    else $error("receive pin steering wrong");
  AST_UART: assert property (
    s.mode[1] |=> (RECEIVE_FRAME_SYNC_INTERNAL == SERIAL_RECEIVE_INTERNAL_INPUT
      && !RECEIVE_FRAME_SYNC_PIN_OE_N))
    else $error("uart wiring wrong");
  AST_BOOT: assert property (
    INT_REQ |-> (!PRAM_WE && PRAM_ADDR == pim_pkg::VT_LAST + 6'h01))
    else $error("dispatch during vector copy");

  COV_TRIP: cover property (INT_REQ && s.cur_idx == 4'h0 && INT_ACK);
  COV_UART: cover property (s.mode[1] && !RECEIVE_FRAME_SYNC_PIN_OE_N);
  COV_NEST: cover property (INT_REQ && s.insvc != 9'h000);
endmodule

// ==== tb/pim_far_end.sv ====
`timescale 1ns/1ps
module pim_far_end
(
  input wire logic clk,
  input wire logic rx_sel_b,
  input wire logic trip_n,
  input wire logic current_sense_input_oc,
  input wire logic [8:0] io,
  input wire logic rx_bit,
  output pim_pkg::pim_pins_type pins
);
  logic idle = 1'b0;
  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // the idle receive pin toggles so that a wrong mux cannot match by luck
  always @(posedge clk) idle <= !idle;
  assign pins = {trip_n, current_sense_input_oc, io, rx_sel_b ? idle : rx_bit,
    rx_sel_b ? rx_bit : idle, !idle};
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, aw = 1'b0, wv = 1'b0, ar = 1'b0, bready = 1'b0;
  logic rready = 1'b0, sync_p = 1'b0, timer = 1'b0, flag_o = 1'b0, ack = 1'b0, ret_p = 1'b0;
  logic trip_n = 1'b1, oc = 1'b0, rxsel = 1'b0, rxbit = 1'b0;
  logic [1:0] ser_n = 2'h3;
  logic [8:0] io = '0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_d, rb;
  logic [1:0] rresp, rd_r, bresp, wr_r;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, line_n, int_req, pram_we, rx_int, fs_int, fs_o;
  logic fs_oe_n;
  logic [15:0] vec;
  logic [5:0] paddr, a;
  logic [7:0] gpio;
  logic [23:0] pdata;
  pim_pkg::pim_pins_type pins;
  int fails = 0, tests_run = 0, cyc = 0, seed = 23, n, k, j, e, b, m;

  pim_far_end pim_far_end_i
  (
    .clk(clk), .rx_sel_b(rxsel), .trip_n(trip_n), .current_sense_input_oc(oc), .io(io), .rx_bit(rxbit),
    .pins(pins)
  );
  pim_top #(.DEFAULT_VECTOR_WORD(24'h5A3C0F)) pim_top_i
  (
    .CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PINS(pins), .PWM_PERIOD_SYNC_PULSE(sync_p),
    .TIMER_IRQ(timer), .SERIAL_RECEIVE_IRQ_N(ser_n[0]), .SERIAL_TRANSMIT_IRQ_N(ser_n[1]),
    .CORE_FLAG_OUTPUT(flag_o), .INT_ACK(ack), .INT_RETURN(ret_p),
    .SHARED_PERIPHERAL_IRQ_LINE_N(line_n), .INT_REQ(int_req), .INT_VECTOR(vec),
    .PRAM_WE(pram_we), .PRAM_ADDR(paddr), .PRAM_DATA(pdata),
    .SERIAL_RECEIVE_INTERNAL_INPUT(rx_int),
    .RECEIVE_FRAME_SYNC_INTERNAL(fs_int), .RECEIVE_FRAME_SYNC_PIN_O(fs_o),
    .RECEIVE_FRAME_SYNC_PIN_OE_N(fs_oe_n), .PIN_IS_GPIO(gpio)
  );

  always #25 clk = !clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out;
    end
  end
  // ------------------------------------------------------------
  // bus, interrupt and check tasks
  // ------------------------------------------------------------
  task close_out;
  begin
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
  begin
    tests_run++;
    if (g !== x)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  end
  endtask
  function logic [31:0] io_exp(input int line);
    return line < 8 ? 32'h1 << line : 32'h1;
  endfunction
  task wr(input logic [15:0] i, input logic [31:0] d);
  begin
    awaddr <= {i, 2'h0};
    wdata <= d;
    aw <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy) aw <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  end
  endtask
  task rd(input logic [15:0] i);
  begin
    araddr <= {i, 2'h0};
    ar <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy) ar <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  end
  endtask
  // waits for a request, checks its vector and acknowledges it
  task svc(input logic [15:0] v);
    int w;
  begin
    w = 0;
    while (int_req !== 1'b1 && w < 100)
    begin
      @(posedge clk);
      w++;
    end
    chk({int_req, vec}, {1'b1, v});
    if (int_req === 1'b1) ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
  end
  endtask
  task ret;
  begin
    ret_p <= 1'b1;
    @(posedge clk);
    ret_p <= 1'b0;
    @(posedge clk);
  end
  endtask
  task quiet;
    int q;
  begin
    q = 0;
    repeat (12)
    begin
      @(posedge clk);
      if (int_req !== 1'b0) q++;
    end
    chk(q, 0);
  end
  endtask
  task sync_pulse;
  begin
    sync_p <= 1'b1;
    @(posedge clk);
    sync_p <= 1'b0;
  end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    chk(gpio, 8'hFF);
    n = 0;
    while (pram_we === 1'b1 && n < 100)
    begin
      a = paddr;
      @(posedge clk);
      n++;
    end
    chk(a, pim_pkg::VT_LAST);
    chk(pdata, 24'h5A3C0F);
    rd(pim_pkg::R_PERIPH_IRQ_EN);
    chk(rd_d, 32'h3);
    rd(16'h2100);
    chk(rd_r, pim_pkg::RESP_SLVERR);
    wr(16'h2100, 32'h1);
    chk(wr_r, pim_pkg::RESP_SLVERR);
    sync_pulse;
    quiet;
    chk(line_n, 1'b0);
    rd(pim_pkg::R_PERIPH_FLAGS);
    chk(rd_d, 32'h2);
    @(posedge clk);
    chk(line_n, 1'b1);
    wr(pim_pkg::R_INT_SENSE_CTRL, 32'h0);
    chk(wr_r, pim_pkg::RESP_OKAY);
    wr(pim_pkg::R_INT_MASK, 32'h207);
    sync_pulse;
    svc(16'h000C);
    rd(pim_pkg::R_PERIPH_FLAGS);
    rd(pim_pkg::R_PERIPH_FLAGS);
    chk(rd_d, 32'h0);
    ret;
    for (k = 0; k < 3; k++)
    begin
      if (k == 0) wr(pim_pkg::R_SW_SHUTDOWN, 32'h1);
      trip_n <= (k != 1);
      oc <= (k == 2);
      svc(16'h002C);
      rd(pim_pkg::R_PERIPH_FLAGS);
      chk(rd_d, 32'h1);
      trip_n <= 1'b1;
      oc <= 1'b0;
      ret;
    end
    wr(pim_pkg::R_IO_IRQ_EN_0_7, 32'hFF);
    wr(pim_pkg::R_IO_IRQ_EN_8, 32'h1);
    for (k = 0; k < 4; k++)
    begin
      j = {$random(seed)} % 9;
      for (e = 0; e < 2; e++)
      begin
        io[j] <= !io[j];
        svc(16'h0008);
        rd(j < 8 ? pim_pkg::R_IO_FLAGS_0_7 : pim_pkg::R_IO_FLAG_8);
        chk(rd_d, io_exp(j));
        rd(j < 8 ? pim_pkg::R_IO_FLAGS_0_7 : pim_pkg::R_IO_FLAG_8);
        chk(rd_d, 32'h0);
        ret;
      end
    end
    timer <= 1'b1;
    @(posedge clk);
    timer <= 1'b0;
    svc(16'h0028);
    ret;
    for (b = 0; b < 2; b++)
      for (e = 0; e < 2; e++)
      begin
        wr(pim_pkg::R_INT_SENSE_CTRL, e << b);
        ser_n[b] <= 1'b0;
        svc(b ? 16'h0020 : 16'h0024);
        ret;
        if (e) quiet;
        else svc(b ? 16'h0020 : 16'h0024);
        ser_n[b] <= 1'b1;
        @(posedge clk);
        if (!e) ret;
      end
    wr(pim_pkg::R_INT_MASK, 32'h200);
    wr(pim_pkg::R_INT_FORCE_CLEAR, 32'h800);
    wr(pim_pkg::R_INT_FORCE_CLEAR, 32'h8);
    wr(pim_pkg::R_INT_MASK, 32'h218);
    quiet;
    wr(pim_pkg::R_INT_FORCE_CLEAR, 32'h1800);
    svc(16'h0018);
    ret;
    svc(16'h001C);
    ret;
    wr(pim_pkg::R_INT_SENSE_CTRL, 32'h10);
    wr(pim_pkg::R_INT_FORCE_CLEAR, 32'h800);
    svc(16'h001C);
    wr(pim_pkg::R_INT_FORCE_CLEAR, 32'h1000);
    svc(16'h0018);
    ret;
    ret;
    for (m = 0; m < 2; m++)
    begin
      wr(pim_pkg::R_MODE_CTRL, m << 4);
      rxsel <= m[0];
      for (k = 0; k < 4; k++)
      begin
        rb = $random(seed);
        rxbit <= rb[0];
        repeat (5) @(posedge clk);
        chk(rx_int, rxbit);
      end
    end
    chk(fs_oe_n, 1'b1);
    wr(pim_pkg::R_MODE_CTRL, 32'h30);
    rb = $random(seed);
    flag_o <= rb[0];
    repeat (5) @(posedge clk);
    chk(fs_oe_n, 1'b0);
    chk(fs_o, flag_o);
    chk(fs_int, rx_int);
    wr(pim_pkg::R_PIN_FUNC_SEL, 32'hD0);
    @(posedge clk);
    chk(gpio, 8'hD0);
    close_out;
  end
endmodule
